// ---- amp_i2c_ctrl.v ----
// I2C target, register map and channel fault actions of a four-channel amplifier.
// Assumes SCL, SDA, strap and mute pins are asynchronous; other inputs share clock_in.
`timescale 1ns/1ps
`include "amp_i2c_defs.vh"

module amp_i2c_ctrl #(
  parameter CM_CYCLES   = `CM_RAMP_CYCLES,
  parameter GAIN_CYCLES = `GAIN_RAMP_CYCLES,
  parameter OC_CYCLES   = `OC_TIMER_CYCLES
) (
  input  wire        clock_in,
  input  wire        rst_in,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe_out,
  input  wire [1:0]  addr_strap_in,
  input  wire        mute_n_in,
  input  wire [3:0]  cycle_current_limit_in,
  input  wire [3:0]  dc_detect_in,
  input  wire [3:0]  clip_in,
  input  wire        thermal_gain_reduction_in,
  input  wire        otsd_in,
  input  wire        diag_done_in,
  input  wire [15:0] diag_result_in,
  output reg  [3:0]  current_limit_out,
  output reg  [3:0]  channel_hiz_out,
  output reg         diag_run_out,
  output reg         gain_reduce_out,
  output reg         cm_ramp_out,
  output reg         gain_ramp_out,
  output reg         play_out,
  output reg         fault_pin_out,
  output reg         fault_pin_oe_out,
  output reg         clip_or_thermal_warning_pin_out,
  output reg         clip_or_thermal_warning_pin_oe_out
);

  localparam [4:0] S_IDLE = 5'b0_0001;
  localparam [4:0] S_RX   = 5'b0_0010;
  localparam [4:0] S_ACK  = 5'b0_0100;
  localparam [4:0] S_TX   = 5'b0_1000;
  localparam [4:0] S_RACK = 5'b1_0000;

  localparam [1:0] P_ADDR = 2'd0;
  localparam [1:0] P_SUB  = 2'd1;
  localparam [1:0] P_DATA = 2'd2;

  localparam [4:0] M_MUTED = 5'b0_0001;
  localparam [4:0] M_CM    = 5'b0_0010;
  localparam [4:0] M_UP    = 5'b0_0100;
  localparam [4:0] M_PLAY  = 5'b0_1000;
  localparam [4:0] M_DOWN  = 5'b1_0000;

  reg  [2:0]  scl_q;
  reg  [2:0]  sda_q;
  reg  [1:0]  strap1_q;
  reg  [1:0]  strap2_q;
  reg         mute1_q;
  reg         mute2_q;
  reg  [4:0]  state_q;
  reg  [1:0]  phase_q;
  reg  [3:0]  cnt_q;
  reg  [7:0]  shift_q;
  reg  [7:0]  ptr_q;
  reg         rw_q;
  reg         nack_q;
  reg  [7:0]  ctrl_q [0:6];
  reg  [3:0]  oc_fault_q;
  reg  [3:0]  dc_fault_q;
  reg         otsd_fault_q;
  reg  [15:0] diag_q;
  reg  [4:0]  mstate_q;
  reg  [31:0] ramp_q;
  reg  [15:0] oc_cnt_q [0:3];

  wire        scl_rise = scl_q[1] & ~scl_q[2];
  wire        scl_fall = ~scl_q[1] & scl_q[2];
  wire        start_c  = scl_q[1] & ~sda_q[1] & sda_q[2];
  wire        stop_c   = scl_q[1] & sda_q[1] & ~sda_q[2];
  wire [3:0]  hiz      = oc_fault_q | dc_fault_q | ctrl_q[4][3:0];
  wire        clear_rd = (state_q == S_RACK) & scl_rise;
  wire        wr_byte  = (state_q == S_RX) & scl_fall & (cnt_q == 4'd8) & (phase_q == P_DATA);
  wire [7:0]  rd_now;

  // Maps a writable sub-address to its control slot; 7 marks no writable register.
  function [2:0] ctrl_slot;
    input [7:0] sub;
    begin
      case (sub)
        `SUB_GAIN_CONTROL:        ctrl_slot = 3'd0;
        `SUB_OVERCURRENT_CONTROL: ctrl_slot = 3'd1;
        `SUB_SWITCH_CLIP_CONTROL: ctrl_slot = 3'd2;
        `SUB_DIAG_MODE_CONTROL:   ctrl_slot = 3'd3;
        `SUB_OUTPUT_CONTROL_A:    ctrl_slot = 3'd4;
        `SUB_OUTPUT_CONTROL_B:    ctrl_slot = 3'd5;
        `SUB_DC_THRESHOLD:        ctrl_slot = 3'd6;
        default:                  ctrl_slot = 3'd7;
      endcase
    end
  endfunction

  // Returns the byte read back at a sub-address; unused addresses read zero.
  function [7:0] read_byte;
    input [7:0] sub;
    begin
      case (sub)
        `SUB_LATCHED_GLOBAL:   read_byte = {4'h0, otsd_fault_q, |oc_fault_q, |dc_fault_q, 1'b0};
        `SUB_LATCHED_CHANNEL:  read_byte = {dc_fault_q, oc_fault_q};
        `SUB_LOAD_DIAG_LOW:    read_byte = diag_q[7:0];
        `SUB_LOAD_DIAG_HIGH:   read_byte = diag_q[15:8];
        `SUB_TEMP_VOLTAGE:     read_byte = {3'b000, otsd_in, 4'h0};
        `SUB_OUTPUT_STATE:     read_byte = {4'h0, hiz};
        `SUB_MUTE_PLAY:        read_byte = {3'b000, mstate_q};
        `SUB_LOAD_DIAG_STATUS: read_byte = {7'h00, diag_run_out};
        `SUB_THERMAL_FOLDBACK: read_byte = {6'h00, thermal_gain_reduction_in, otsd_in};
        default: begin
          if (ctrl_slot(sub) != 3'd7) begin
            read_byte = ctrl_q[ctrl_slot(sub)];
          end else begin
            read_byte = 8'h00;
          end
        end
      endcase
    end
  endfunction

  assign rd_now = read_byte(ptr_q);

  // Pin synchronisers; the first stage feeds only the second.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      scl_q    <= 3'b111;
      sda_q    <= 3'b111;
      strap1_q <= 2'b00;
      strap2_q <= 2'b00;
      mute1_q  <= 1'b0;
      mute2_q  <= 1'b0;
    end else begin
      scl_q    <= {scl_q[1:0], scl_in};
      sda_q    <= {sda_q[1:0], sda_in};
      strap1_q <= addr_strap_in;
      strap2_q <= strap1_q;
      mute1_q  <= mute_n_in;
      mute2_q  <= mute1_q;
    end
  end

  // Bus protocol engine.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q    <= S_IDLE;
      phase_q    <= P_ADDR;
      cnt_q      <= 4'd0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      rw_q       <= 1'b0;
      nack_q     <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (stop_c) begin
      state_q    <= S_IDLE;
      sda_oe_out <= 1'b0;
    end else if (start_c) begin
      state_q    <= S_RX;
      phase_q    <= P_ADDR;
      cnt_q      <= 4'd0;
      sda_oe_out <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          cnt_q <= 4'd0;
        end
        S_RX: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_q[1]};
            cnt_q   <= cnt_q + 4'd1;
          end else if (scl_fall && cnt_q == 4'd8) begin
            if (phase_q == P_ADDR) begin
              if (shift_q[7:1] == {`ADDR_FIXED, strap2_q}) begin
                rw_q       <= shift_q[0];
                sda_oe_out <= 1'b1;
                state_q    <= S_ACK;
              end else begin
                state_q <= S_IDLE;
              end
            end else if (phase_q == P_SUB) begin
              ptr_q      <= shift_q;
              sda_oe_out <= 1'b1;
              state_q    <= S_ACK;
            end else begin
              ptr_q      <= ptr_q + 8'd1;
              sda_oe_out <= 1'b1;
              state_q    <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            cnt_q <= 4'd0;
            if (phase_q == P_ADDR && rw_q) begin
              shift_q    <= rd_now;
              sda_oe_out <= ~rd_now[7];
              state_q    <= S_TX;
            end else begin
              sda_oe_out <= 1'b0;
              phase_q    <= (phase_q == P_ADDR) ? P_SUB : P_DATA;
              state_q    <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'd1;
          end else if (scl_fall) begin
            if (cnt_q == 4'd8) begin
              sda_oe_out <= 1'b0;
              state_q    <= S_RACK;
            end else begin
              shift_q    <= {shift_q[6:0], 1'b0};
              sda_oe_out <= ~shift_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_q[1];
            ptr_q  <= ptr_q + 8'd1;
          end else if (scl_fall) begin
            cnt_q <= 4'd0;
            if (nack_q) begin
              state_q <= S_IDLE;
            end else begin
              shift_q    <= rd_now;
              sda_oe_out <= ~rd_now[7];
              state_q    <= S_TX;
            end
          end
        end
        default: begin
          state_q    <= S_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Control registers; read-only and unused addresses ignore writes.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_ctrl
      always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          ctrl_q[gi] <= `CTRL_RESET;
        end else if (wr_byte && ctrl_slot(ptr_q) == gi) begin
          ctrl_q[gi] <= shift_q;
        end
      end
    end
  endgenerate

  // Per-channel overcurrent timer, latched faults and current limiting.
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          oc_cnt_q[gi]          <= 16'h0000;
          oc_fault_q[gi]        <= 1'b0;
          dc_fault_q[gi]        <= 1'b0;
          current_limit_out[gi] <= 1'b0;
        end else begin
          current_limit_out[gi] <= cycle_current_limit_in[gi];
          if (!cycle_current_limit_in[gi]) begin
            oc_cnt_q[gi] <= 16'h0000;
          end else if (oc_cnt_q[gi] != OC_CYCLES[15:0]) begin
            oc_cnt_q[gi] <= oc_cnt_q[gi] + 16'h0001;
          end
          if (cycle_current_limit_in[gi] && oc_cnt_q[gi] == OC_CYCLES[15:0] - 16'h0001) begin
            oc_fault_q[gi] <= 1'b1;
          end else if (clear_rd && ptr_q == `SUB_LATCHED_CHANNEL) begin
            oc_fault_q[gi] <= 1'b0;
          end
          if (dc_detect_in[gi]) begin
            dc_fault_q[gi] <= 1'b1;
          end else if (clear_rd && ptr_q == `SUB_LATCHED_CHANNEL) begin
            dc_fault_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Global shutdown latch, diagnostic capture and warning pins.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      otsd_fault_q                       <= 1'b0;
      diag_q                             <= 16'h0000;
      diag_run_out                       <= 1'b0;
      channel_hiz_out                    <= 4'hF;
      gain_reduce_out                    <= 1'b0;
      fault_pin_out                      <= 1'b0;
      fault_pin_oe_out                   <= 1'b0;
      clip_or_thermal_warning_pin_out    <= 1'b0;
      clip_or_thermal_warning_pin_oe_out <= 1'b0;
    end else begin
      if (otsd_in) begin
        otsd_fault_q <= 1'b1;
      end else if (clear_rd && ptr_q == `SUB_LATCHED_GLOBAL) begin
        otsd_fault_q <= 1'b0;
      end
      diag_run_out <= ctrl_q[3][`DIAG_START_BIT] & (&hiz);
      if (diag_done_in && diag_run_out) begin
        diag_q <= diag_q | diag_result_in;
      end else if (clear_rd && ptr_q == `SUB_LOAD_DIAG_LOW) begin
        diag_q[7:0] <= 8'h00;
      end else if (clear_rd && ptr_q == `SUB_LOAD_DIAG_HIGH) begin
        diag_q[15:8] <= 8'h00;
      end
      channel_hiz_out  <= hiz;
      gain_reduce_out  <= thermal_gain_reduction_in;
      fault_pin_oe_out <= (|oc_fault_q) | (|dc_fault_q) | otsd_fault_q;
      clip_or_thermal_warning_pin_oe_out <=
        ((|clip_in) & (play_out | mute2_q)) | thermal_gain_reduction_in;
    end
  end

  // Mute pin sequencing: common-mode ramp, then gain ramp, then play.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mstate_q      <= M_MUTED;
      ramp_q        <= 32'd0;
      cm_ramp_out   <= 1'b0;
      gain_ramp_out <= 1'b0;
      play_out      <= 1'b0;
    end else begin
      cm_ramp_out   <= (mstate_q == M_CM);
      gain_ramp_out <= (mstate_q == M_UP) | (mstate_q == M_DOWN);
      play_out      <= (mstate_q == M_PLAY);
      case (mstate_q)
        M_MUTED: begin
          ramp_q <= 32'd0;
          if (mute2_q) begin
            mstate_q <= M_CM;
          end
        end
        M_CM: begin
          ramp_q <= ramp_q + 32'd1;
          if (!mute2_q) begin
            mstate_q <= M_MUTED;
          end else if (ramp_q == CM_CYCLES - 1) begin
            ramp_q   <= 32'd0;
            mstate_q <= M_UP;
          end
        end
        M_UP: begin
          ramp_q <= ramp_q + 32'd1;
          if (!mute2_q) begin
            ramp_q   <= 32'd0;
            mstate_q <= M_DOWN;
          end else if (ramp_q == GAIN_CYCLES - 1) begin
            mstate_q <= M_PLAY;
          end
        end
        M_PLAY: begin
          ramp_q <= 32'd0;
          if (!mute2_q) begin
            mstate_q <= M_DOWN;
          end
        end
        M_DOWN: begin
          ramp_q <= ramp_q + 32'd1;
          if (ramp_q == GAIN_CYCLES - 1) begin
            mstate_q <= M_MUTED;
          end
        end
        default: begin
          mstate_q <= M_MUTED;
        end
      endcase
    end
  end

endmodule // amp_i2c_ctrl

// ---- amp_i2c_defs.vh ----
// Constants for the amplifier I2C target and channel fault logic.
// Included by amp_i2c_ctrl.v; holds definitions only.
`ifndef AMP_I2C_DEFS_VH
`define AMP_I2C_DEFS_VH

`define ADDR_FIXED              5'b1_1011
`define SUB_LATCHED_GLOBAL      8'h00
`define SUB_LATCHED_CHANNEL     8'h01
`define SUB_LOAD_DIAG_LOW       8'h02
`define SUB_LOAD_DIAG_HIGH      8'h03
`define SUB_TEMP_VOLTAGE        8'h04
`define SUB_OUTPUT_STATE        8'h05
`define SUB_MUTE_PLAY           8'h06
`define SUB_LOAD_DIAG_STATUS    8'h07
`define SUB_GAIN_CONTROL        8'h08
`define SUB_OVERCURRENT_CONTROL 8'h09
`define SUB_SWITCH_CLIP_CONTROL 8'h0A
`define SUB_DIAG_MODE_CONTROL   8'h0B
`define SUB_OUTPUT_CONTROL_A    8'h0C
`define SUB_OUTPUT_CONTROL_B    8'h0D
`define SUB_DC_THRESHOLD        8'h10
`define SUB_THERMAL_FOLDBACK    8'h13
`define CTRL_RESET              8'h00
`define DIAG_START_BIT          0
`define GLOBAL_OTSD_BIT         3
`define GLOBAL_OC_BIT           2
`define GLOBAL_DC_BIT           1
`define TEMP_OTSD_BIT           4
`define FOLD_OTSD_BIT           0
`define FOLD_ACTIVE_BIT         1
`define CLK_HZ                  40000000
`define CM_RAMP_MS              26
`define GAIN_RAMP_MS            76
`define CM_RAMP_CYCLES          ((`CM_RAMP_MS * `CLK_HZ) / 1000)
`define GAIN_RAMP_CYCLES        ((`GAIN_RAMP_MS * `CLK_HZ) / 1000)
`define OC_TIMER_CYCLES         64

`endif

// ---- amp_i2c_ctrl_sva.sv ----
// Concurrent checks on the ports of the amplifier I2C target and fault logic.
// Assumes one clock domain, clock_in, with rst_in as asynchronous active-high reset.
`timescale 1ns/1ps
module amp_i2c_chk #(
  parameter CM_CYCLES   = 20,
  parameter GAIN_CYCLES = 40,
  parameter OC_CYCLES   = 64
) (
  input wire       clock_in,
  input wire       rst_in,
  input wire       mute_n_in,
  input wire [3:0] cycle_current_limit_in,
  input wire [3:0] dc_detect_in,
  input wire [3:0] clip_in,
  input wire       thermal_gain_reduction_in,
  input wire       sda_oe_out,
  input wire [3:0] channel_hiz_out,
  input wire       diag_run_out,
  input wire       gain_reduce_out,
  input wire       cm_ramp_out,
  input wire       gain_ramp_out,
  input wire       play_out,
  input wire       fault_pin_oe_out,
  input wire       clip_or_thermal_warning_pin_oe_out
);
  int oc_cnt_q;
  // Counts consecutive cycles of current limit on channel 1.
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      oc_cnt_q <= 0;
    end else if (!cycle_current_limit_in[1]) begin
      oc_cnt_q <= 0;
    end else if (oc_cnt_q < 1000) begin
      oc_cnt_q <= oc_cnt_q + 1;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_oc_isolates: assert property (oc_cnt_q >= OC_CYCLES + 4 |-> channel_hiz_out[1])
    else $error("overcurrent did not isolate channel");
  chk_dc_isolates: assert property (dc_detect_in[2] |-> ##[1:3] channel_hiz_out[2] [*4])
    else $error("dc offset did not isolate channel");
  chk_dc_fault_pin: assert property ((|dc_detect_in) |-> ##[1:3] fault_pin_oe_out)
    else $error("dc offset not shown on fault pin");
  chk_fold_sets: assert property (thermal_gain_reduction_in |->
    ##[1:3] (gain_reduce_out && clip_or_thermal_warning_pin_oe_out))
    else $error("foldback not applied or not reported");
  chk_fold_clears: assert property (!thermal_gain_reduction_in [*3] |-> !gain_reduce_out)
    else $error("foldback did not clear");
  chk_warn_clears: assert property ((clip_in == 4'h0 && !thermal_gain_reduction_in) [*3]
    |-> !clip_or_thermal_warning_pin_oe_out)
    else $error("warning pin did not clear");
  chk_mute_stops: assert property (!mute_n_in [*6] |-> !play_out)
    else $error("play state kept while muted");
  chk_play_order: assert property ($rose(play_out) |-> $past(gain_ramp_out))
    else $error("play entered without gain ramp");
  chk_gain_order: assert property ($rose(gain_ramp_out) |->
    ($past(cm_ramp_out) || $past(play_out)))
    else $error("gain ramp entered without common-mode ramp or play");
  chk_diag_hiz_only: assert property (diag_run_out |-> channel_hiz_out == 4'hF)
    else $error("diagnostic running with outputs active");
  cov_play: cover property ($rose(play_out));
  cov_diag: cover property ($rose(diag_run_out));
  cov_ack: cover property ($rose(sda_oe_out));
endmodule // amp_i2c_chk

bind amp_i2c_ctrl amp_i2c_chk #(.CM_CYCLES(CM_CYCLES), .GAIN_CYCLES(GAIN_CYCLES),
  .OC_CYCLES(OC_CYCLES)) chk_u (.*);

// ---- i2c_ctl_model.sv ----
// Behavioural I2C bus controller driving the target from the far side.
// Assumes SDA and SCL are pulled up; the bench resolves the SDA wire.
`timescale 1ns/1ps
module i2c_ctl_model (
  input  wire  clk_in,
  input  wire  sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  int slow = 0;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    tick(1); sda_low_out <= 1'b0;
    tick(4); scl_out <= 1'b1;
    tick(4); sda_low_out <= 1'b1;
    tick(4); scl_out <= 1'b0;
  endtask
  task automatic stop();
    tick(1); sda_low_out <= 1'b1;
    tick(3 + slow); scl_out <= 1'b1;
    tick(4); sda_low_out <= 1'b0;
    tick(4);
  endtask
  task automatic bit_x(input logic b, output logic r);
    tick(1); sda_low_out <= !b;
    tick(3 + slow); scl_out <= 1'b1;
    tick(3); r = sda_in;
    tick(1); scl_out <= 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // The last byte of a read is answered with not-acknowledge.
  task automatic get(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule // i2c_ctl_model

// ---- testbench.sv ----
// Self-checking bench for the amplifier I2C target and fault logic.
// Assumes amp_i2c_ctrl, its checker and the controller model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic clock_in, rst_in;
  logic [1:0] addr_strap_in;
  logic mute_n_in, thermal_gain_reduction_in, otsd_in, diag_done_in;
  logic [3:0] cycle_current_limit_in, dc_detect_in, clip_in;
  logic [15:0] diag_result_in;
  wire sda_oe_out, diag_run_out, play_out, fault_pin_oe_out, warn_oe, scl_w, sda_low, gred;
  wire [3:0] current_limit_out, channel_hiz_out;
  wire sda_w = !(sda_low | sda_oe_out);
  int n_errors = 0, checks_done = 0, cyc = 0;
  logic [31:0] rnd = 32'h343f_aa8a;
  logic [7:0] dev, rq[$], d[$];
  logic a;
  amp_i2c_ctrl #(.CM_CYCLES(20), .GAIN_CYCLES(40), .OC_CYCLES(64)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w), .sda_out(),
    .sda_oe_out(sda_oe_out), .addr_strap_in(addr_strap_in), .mute_n_in(mute_n_in),
    .cycle_current_limit_in(cycle_current_limit_in), .dc_detect_in(dc_detect_in),
    .clip_in(clip_in), .thermal_gain_reduction_in(thermal_gain_reduction_in),
    .otsd_in(otsd_in), .diag_done_in(diag_done_in), .diag_result_in(diag_result_in),
    .current_limit_out(current_limit_out), .channel_hiz_out(channel_hiz_out),
    .diag_run_out(diag_run_out), .gain_reduce_out(gred), .cm_ramp_out(), .gain_ramp_out(),
    .play_out(play_out), .fault_pin_out(), .fault_pin_oe_out(fault_pin_oe_out),
    .clip_or_thermal_warning_pin_out(), .clip_or_thermal_warning_pin_oe_out(warn_oe));
  i2c_ctl_model m (.clk_in(clock_in), .sda_in(sda_w), .scl_out(scl_w), .sda_low_out(sda_low));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = !clock_in;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ctl_exp(input logic [7:0] sub, input logic [7:0] v);
    return (sub == 8'h0E || sub == 8'h0F) ? 8'h00 : v;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] v[$]);
    m.start(); m.put(dev, a); chk(a, 8'h01);
    m.put(sub, a); chk(a, 8'h01);
    foreach (v[i]) begin m.put(v[i], a); chk(a, 8'h01); end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] sub, input int n);
    logic [7:0] v;
    rq = {};
    m.start(); m.put(dev, a); m.put(sub, a); m.start();
    m.put(dev | 8'h01, a); chk(a, 8'h01);
    for (int i = 0; i < n; i++) begin m.get(v, i == n - 1); rq.push_back(v); end
    m.stop();
  endtask
  task automatic rc(input logic [7:0] sub, input logic [7:0] exp);
    rd(sub, 1); chk(rq[0], exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 90000) begin n_errors++; complete_run(); end
  end
  initial begin
    rst_in = 1'b1; addr_strap_in = 2'b00; mute_n_in = 1'b0; otsd_in = 1'b0;
    thermal_gain_reduction_in = 1'b0; diag_done_in = 1'b0; diag_result_in = 16'h0000;
    cycle_current_limit_in = 4'h0; dc_detect_in = 4'h0; clip_in = 4'h0;
    wt(20); rst_in <= 1'b0; wt(4);
    chk(channel_hiz_out, 8'h00);
    for (int s = 0; s < 4; s++) begin
      addr_strap_in <= s[1:0]; dev = {5'b1_1011, s[1:0], 1'b0}; rnd = nxt(rnd); wt(4);
      m.slow = s; wr(8'h08, {rnd[7:0]}); rc(8'h08, rnd[7:0]);
    end
    m.slow = 0;
    m.start(); m.put(8'hD8, a); chk(a, 8'h00); m.stop();
    d = {};
    for (int i = 0; i < 9; i++) begin rnd = nxt(rnd); d.push_back(rnd[7:0]); end
    wr(8'h08, d); rd(8'h08, 9);
    foreach (d[i]) chk(rq[i], ctl_exp(8'h08 + i[7:0], d[i]));
    wr(8'h08, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(8'h00, {8'hFF, 8'hFF}); wr(8'h04, {8'hFF}); rd(8'h00, 2);
    chk(rq[0], 8'h00); chk(rq[1], 8'h00); rc(8'h04, 8'h00);
    otsd_in <= 1'b1; thermal_gain_reduction_in <= 1'b1; wt(4);
    rc(8'h13, 8'h03); rc(8'h04, 8'h10); chk(fault_pin_oe_out, 8'h01);
    chk(gred, 8'h01); chk(warn_oe, 8'h01);
    otsd_in <= 1'b0; thermal_gain_reduction_in <= 1'b0; wt(4);
    rc(8'h00, 8'h08); rc(8'h00, 8'h00); rc(8'h13, 8'h00);
    dc_detect_in <= 4'b0100; wt(1); dc_detect_in <= 4'h0; wt(3);
    chk(channel_hiz_out, 8'h04); chk(fault_pin_oe_out, 8'h01);
    rd(8'h00, 2); chk(rq[0], 8'h02); chk(rq[1], 8'h40);
    cycle_current_limit_in <= 4'b0010; wt(30); cycle_current_limit_in <= 4'h0; wt(4);
    chk(channel_hiz_out[1], 8'h00); rc(8'h01, 8'h00);
    cycle_current_limit_in <= 4'b0010; wt(3); chk(current_limit_out, 8'h02);
    wt(70); cycle_current_limit_in <= 4'h0; wt(3);
    chk(channel_hiz_out[1], 8'h01); rc(8'h01, 8'h02);
    wr(8'h0B, {8'h01}); wt(4); chk(diag_run_out, 8'h00);
    wr(8'h0C, {8'h0F}); wt(4); chk(diag_run_out, 8'h01);
    rnd = nxt(rnd); diag_result_in <= rnd[15:0]; diag_done_in <= 1'b1;
    wt(1); diag_done_in <= 1'b0; rd(8'h02, 2);
    chk(rq[0], rnd[7:0]); chk(rq[1], rnd[15:8]); wr(8'h0B, {8'h00, 8'h00});
    clip_in <= 4'hF; wt(5); chk(warn_oe, 8'h00); clip_in <= 4'h0;
    mute_n_in <= 1'b1; wt(30); chk(play_out, 8'h00);
    wt(45); chk(play_out, 8'h01); rc(8'h06, 8'h08);
    rnd = nxt(rnd); clip_in <= rnd[3:0] | 4'h1; wt(5);
    chk(warn_oe, 8'h01); chk(channel_hiz_out[0], 8'h00); clip_in <= 4'h0;
    mute_n_in <= 1'b0; wt(8); chk(play_out, 8'h00);
    complete_run();
  end
endmodule // testbench
